//--- verilog/scoc_defs.svh
`ifndef SCOC_DEFS_SVH
`define SCOC_DEFS_SVH

// ------------------------------------------------------------
// Register location and layout
// ------------------------------------------------------------
`define SCOC_ADDR_W 8
`define SCOC_DATA_W 16
`define SCOC_REG_ADDR 8'h03
`define SCOC_CYC_HI 15
`define SCOC_CYC_LO 13
`define SCOC_DTO_HI 12
`define SCOC_DTO_LO 10
`define SCOC_DRVEN_BIT 7
`define SCOC_DIAG_BIT 6
`define SCOC_HOLD_BIT 5
`define SCOC_SRST_BIT 4
`define SCOC_WAVE_BIT 3
`define SCOC_HBL_HI 2
`define SCOC_HBL_LO 1
`define SCOC_CFG_RST 16'h1001
`define SCOC_CFG_WMASK 16'hffaf

// ------------------------------------------------------------
// Field codes
// ------------------------------------------------------------
`define SCOC_CODE_OFF 3'h0
`define SCOC_CODE_CONT 3'h1

// ------------------------------------------------------------
// Clock and times, each in its own unit
// ------------------------------------------------------------
`define SCOC_CLK_NS 100
`define SCOC_T50_MS 50
`define SCOC_T100_MS 100
`define SCOC_T200_MS 200
`define SCOC_T1000_MS 1000
`define SCOC_T2000_MS 2000
`define SCOC_T4000_MS 4000
`define SCOC_T8000_MS 8000
`define SCOC_HB_HIGH_US 500
`define SCOC_HB_L0_US 500
`define SCOC_HB_L1_US 1000
`define SCOC_HB_L2_US 10000
`define SCOC_HB_L3_US 100000

`endif

//--- verilog/scoc_pkg.sv
`include "scoc_defs.svh"

package scoc_pkg;

  typedef enum {hb_high, hb_low} scoc_hb_phase_t;

  // Times convert exactly at this clock; the 4000 ms figure already needs 64-bit math
  function automatic int scoc_ms2cyc(longint ms);
    return int'((ms * 64'd1000000) / `SCOC_CLK_NS);
  endfunction

  function automatic int scoc_us2cyc(longint us);
    return int'((us * 64'd1000) / `SCOC_CLK_NS);
  endfunction

endpackage

//--- verilog/scoc_timer.sv
`timescale 1ns/10ps

module scoc_timer #(
  parameter int CNT_W = 27
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic restart,
  input wire logic run,
  input wire logic [CNT_W-1:0] reload_val,
  output logic expire
);

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;

  // ------------------------------------------------------------
  // Down counter with automatic reload
  // ------------------------------------------------------------
  always_comb begin
    next_cnt = cnt;
    expire = 1'b0;
    if (restart) begin
      next_cnt = reload_val;
    end else if (run) begin
      if (cnt <= CNT_W'(1)) begin
        next_cnt = reload_val;
        expire = (cnt == CNT_W'(1));
      end else begin
        next_cnt = cnt - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt <= '0;
    end else if (ce) begin
      cnt <= next_cnt;
    end
  end

endmodule

//--- verilog/scoc_top.sv
// Functional notes
// [RULE_01] Periodic measurement launch from cyclic period field
// [RULE_02] Cyclic codes: off, continuous, six periods
// [RULE_03] Diagnostic timeout forces return to normal
// [RULE_04] Zero timeout refuses diagnostic entry
// [RULE_05] Request bit one enters, zero leaves
// [RULE_06] Each request write reloads timeout counter; the code reloads only when the written timeout code is nonzero
// [RULE_07] Bit six reads diagnostic status flag
// [RULE_08] Global enable gates all balancing drivers
// [RULE_09] Manual hold forces switches off, timers run
// [RULE_10] Software reset pulse restores defaults, reads zero
// [RULE_11] Software reset bit cleared only by power-on
// [RULE_12] Level mode: fault pin follows fault
// [RULE_13] Heartbeat mode: 500 us high phases
// [RULE_14] Off-time field selects heartbeat low phase
// [RULE_15] Host preserves reserved bits nine and eight
// [RULE_16] Fault present stops heartbeat, pin high
// [RULE_17] Power-on reset loads documented field defaults
`timescale 1ns/10ps
`include "scoc_defs.svh"

module scoc_top #(
  parameter int N_CELLS = 14,
  parameter int CNT_W = 27,
  parameter int CYC_50MS = scoc_pkg::scoc_ms2cyc(`SCOC_T50_MS),
  parameter int CYC_100MS = scoc_pkg::scoc_ms2cyc(`SCOC_T100_MS),
  parameter int CYC_200MS = scoc_pkg::scoc_ms2cyc(`SCOC_T200_MS),
  parameter int CYC_1S = scoc_pkg::scoc_ms2cyc(`SCOC_T1000_MS),
  parameter int CYC_2S = scoc_pkg::scoc_ms2cyc(`SCOC_T2000_MS),
  parameter int CYC_4S = scoc_pkg::scoc_ms2cyc(`SCOC_T4000_MS),
  parameter int CYC_8S = scoc_pkg::scoc_ms2cyc(`SCOC_T8000_MS),
  parameter int CYC_HB_HIGH = scoc_pkg::scoc_us2cyc(`SCOC_HB_HIGH_US),
  parameter int CYC_HB_L0 = scoc_pkg::scoc_us2cyc(`SCOC_HB_L0_US),
  parameter int CYC_HB_L1 = scoc_pkg::scoc_us2cyc(`SCOC_HB_L1_US),
  parameter int CYC_HB_L2 = scoc_pkg::scoc_us2cyc(`SCOC_HB_L2_US),
  parameter int CYC_HB_L3 = scoc_pkg::scoc_us2cyc(`SCOC_HB_L3_US)
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`SCOC_ADDR_W-1:0] reg_addr,
  input wire logic [`SCOC_DATA_W-1:0] reg_wdata,
  output logic [`SCOC_DATA_W-1:0] reg_rdata,
  input wire logic fault_present,
  input wire logic conv_busy,
  input wire logic [N_CELLS-1:0] per_cell_balance_config,
  output logic [N_CELLS-1:0] balance_switch_on,
  output logic balance_timer_run,
  output logic fault_pin,
  output logic diagnostic_active_flag,
  output logic measure_start,
  output logic soft_reset_pulse
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [`SCOC_DATA_W-1:0] system_config_one;
  logic [`SCOC_DATA_W-1:0] next_system_config_one;
  logic srst_latched;
  logic next_srst_latched;
  logic next_soft_reset_pulse;
  logic next_diagnostic_active_flag;
  logic [`SCOC_DATA_W-1:0] next_reg_rdata;
  logic next_fault_pin;
  logic next_measure_start;
  logic [N_CELLS-1:0] next_balance_switch_on;
  logic next_balance_timer_run;
  scoc_pkg::scoc_hb_phase_t hb_phase;
  scoc_pkg::scoc_hb_phase_t next_hb_phase;

  logic wr_hit;
  logic diag_enter;
  logic diag_expire;
  logic cyc_expire;
  logic cyc_run;
  logic hb_expire;
  logic hb_run;
  logic [2:0] cyc_code;
  logic [2:0] cyc_load_code;
  logic [2:0] dto_wr_code;
  logic [1:0] hbl_code;
  logic [CNT_W-1:0] cyc_val;
  logic [CNT_W-1:0] diag_val;
  logic [CNT_W-1:0] hb_val;
  logic [CNT_W-1:0] hb_low_val;

  assign wr_hit = reg_wr && (reg_addr == `SCOC_REG_ADDR);
  assign cyc_code = system_config_one[`SCOC_CYC_HI:`SCOC_CYC_LO];
  // A write reloads with the code it carries, so the first launch already uses the new period
  assign cyc_load_code = wr_hit ? reg_wdata[`SCOC_CYC_HI:`SCOC_CYC_LO] : cyc_code;
  assign dto_wr_code = reg_wdata[`SCOC_DTO_HI:`SCOC_DTO_LO];
  assign hbl_code = system_config_one[`SCOC_HBL_HI:`SCOC_HBL_LO];

  // ------------------------------------------------------------
  // Period decode
  // ------------------------------------------------------------
  always_comb begin
    // Cyclic period codes
    // [RULE_02] period code decode
    case (cyc_load_code)
      3'h2: cyc_val = CNT_W'(CYC_100MS);
      3'h3: cyc_val = CNT_W'(CYC_200MS);
      3'h4: cyc_val = CNT_W'(CYC_1S);
      3'h5: cyc_val = CNT_W'(CYC_2S);
      3'h6: cyc_val = CNT_W'(CYC_4S);
      3'h7: cyc_val = CNT_W'(CYC_8S);
      default: cyc_val = '0;
    endcase
    // Timeout follows the value written with the request
    // [RULE_04] timeout code decode
    case (dto_wr_code)
      3'h1: diag_val = CNT_W'(CYC_50MS);
      3'h2: diag_val = CNT_W'(CYC_100MS);
      3'h3: diag_val = CNT_W'(CYC_200MS);
      3'h4: diag_val = CNT_W'(CYC_1S);
      3'h5: diag_val = CNT_W'(CYC_2S);
      3'h6: diag_val = CNT_W'(CYC_4S);
      3'h7: diag_val = CNT_W'(CYC_8S);
      default: diag_val = '0;
    endcase
    // [RULE_14] off time select
    case (hbl_code)
      2'h0: hb_low_val = CNT_W'(CYC_HB_L0);
      2'h1: hb_low_val = CNT_W'(CYC_HB_L1);
      2'h2: hb_low_val = CNT_W'(CYC_HB_L2);
      default: hb_low_val = CNT_W'(CYC_HB_L3);
    endcase
  end

  // ------------------------------------------------------------
  // Timers
  // ------------------------------------------------------------
  // [RULE_01] periodic launch timer
  assign cyc_run = (cyc_code != `SCOC_CODE_OFF) && (cyc_code != `SCOC_CODE_CONT);

  scoc_timer #(.CNT_W(CNT_W)) u_cyc_timer (
    .mclk(mclk),
    .rstn(rstn),
    .ce(ce),
    .restart(wr_hit || soft_reset_pulse),
    .run(cyc_run),
    .reload_val(cyc_val),
    .expire(cyc_expire)
  );

  // [RULE_06] reload on every request write with a nonzero timeout code
  scoc_timer #(.CNT_W(CNT_W)) u_diag_timer (
    .mclk(mclk),
    .rstn(rstn),
    .ce(ce),
    .restart(diag_enter),
    .run(diagnostic_active_flag),
    .reload_val(diag_val),
    .expire(diag_expire)
  );

  // Heartbeat restarts from a fresh high phase whenever it resumes
  assign hb_run = system_config_one[`SCOC_WAVE_BIT] && !fault_present;
  assign hb_val = (hb_run && hb_phase == scoc_pkg::hb_high) ? hb_low_val : CNT_W'(CYC_HB_HIGH);

  scoc_timer #(.CNT_W(CNT_W)) u_hb_timer (
    .mclk(mclk),
    .rstn(rstn),
    .ce(ce),
    .restart(!hb_run),
    .run(hb_run),
    .reload_val(hb_val),
    .expire(hb_expire)
  );

  // ------------------------------------------------------------
  // Register, diagnostic mode and reset pulse
  // ------------------------------------------------------------
  always_comb begin
    next_system_config_one = system_config_one;
    next_srst_latched = srst_latched;
    next_soft_reset_pulse = 1'b0;
    next_diagnostic_active_flag = diagnostic_active_flag;
    next_reg_rdata = '0;
    diag_enter = 1'b0;
    // [RULE_04] zero timeout refuses entry
    if (wr_hit && reg_wdata[`SCOC_DIAG_BIT] && dto_wr_code != `SCOC_CODE_OFF && !soft_reset_pulse) begin
      diag_enter = 1'b1;
    end
    if (soft_reset_pulse) begin
      // [RULE_10] defaults restored by pulse
      next_system_config_one = `SCOC_CFG_RST;
      next_diagnostic_active_flag = 1'b0;
    end else begin
      if (wr_hit) begin
        // Request and reset bits are actions, never stored in the image
        next_system_config_one = reg_wdata & `SCOC_CFG_WMASK;
        // [RULE_10] single reset pulse
        if (reg_wdata[`SCOC_SRST_BIT]) begin
          next_soft_reset_pulse = 1'b1;
          next_srst_latched = 1'b1;
        end
      end
      // [RULE_05] enter or leave diagnostic mode
      if (diag_enter) begin
        next_diagnostic_active_flag = 1'b1;
      end else if (wr_hit && !reg_wdata[`SCOC_DIAG_BIT]) begin
        next_diagnostic_active_flag = 1'b0;
      end else if (diag_expire) begin
        // [RULE_03] timeout forces normal mode
        next_diagnostic_active_flag = 1'b0;
      end
    end
    if (reg_rd && reg_addr == `SCOC_REG_ADDR) begin
      next_reg_rdata = system_config_one;
      // [RULE_07] status flag on read
      next_reg_rdata[`SCOC_DIAG_BIT] = diagnostic_active_flag;
      // [RULE_10] reset bit reads zero
      next_reg_rdata[`SCOC_SRST_BIT] = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Measurement launch, balancing and fault pin
  // ------------------------------------------------------------
  always_comb begin
    next_measure_start = 1'b0;
    // [RULE_01] launch on period expiry
    if (cyc_run) begin
      next_measure_start = cyc_expire;
    end else if (cyc_code == `SCOC_CODE_CONT) begin
      // [RULE_02] back-to-back while engine idle
      next_measure_start = !conv_busy && !measure_start;
    end
    // [RULE_08] global driver gate
    next_balance_switch_on = system_config_one[`SCOC_DRVEN_BIT] ? per_cell_balance_config : '0;
    // [RULE_09] hold forces switches off
    if (system_config_one[`SCOC_HOLD_BIT]) begin
      next_balance_switch_on = '0;
    end
    next_balance_timer_run = system_config_one[`SCOC_DRVEN_BIT];
    next_hb_phase = hb_phase;
    if (!hb_run) begin
      next_hb_phase = scoc_pkg::hb_high;
    end else if (hb_expire) begin
      // [RULE_13] alternate fixed high and selected low phases
      case (hb_phase)
        scoc_pkg::hb_high: next_hb_phase = scoc_pkg::hb_low;
        scoc_pkg::hb_low: next_hb_phase = scoc_pkg::hb_high;
        default: next_hb_phase = scoc_pkg::hb_high;
      endcase
    end
    // [RULE_12] level mode follows fault
    // [RULE_16] fault overrides heartbeat
    if (!hb_run) begin
      next_fault_pin = fault_present;
    end else begin
      next_fault_pin = (hb_phase == scoc_pkg::hb_high);
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      // [RULE_17] power-on defaults
      system_config_one <= `SCOC_CFG_RST;
      // [RULE_11] only power-on clears it
      srst_latched <= 1'b0;
      soft_reset_pulse <= 1'b0;
      diagnostic_active_flag <= 1'b0;
      reg_rdata <= '0;
      fault_pin <= 1'b0;
      measure_start <= 1'b0;
      balance_switch_on <= '0;
      balance_timer_run <= 1'b0;
      hb_phase <= scoc_pkg::hb_high;
    end else if (ce) begin
      system_config_one <= next_system_config_one;
      srst_latched <= next_srst_latched;
      soft_reset_pulse <= next_soft_reset_pulse;
      diagnostic_active_flag <= next_diagnostic_active_flag;
      reg_rdata <= next_reg_rdata;
      fault_pin <= next_fault_pin;
      measure_start <= next_measure_start;
      balance_switch_on <= next_balance_switch_on;
      balance_timer_run <= next_balance_timer_run;
      hb_phase <= next_hb_phase;
    end
  end

endmodule

//--- test/scoc_top_assertions.sv
`timescale 1ns/10ps
`include "scoc_defs.svh"
module scoc_top_chk #(
  parameter int N_CELLS = 14
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`SCOC_ADDR_W-1:0] reg_addr,
  input wire logic [`SCOC_DATA_W-1:0] reg_wdata,
  input wire logic [`SCOC_DATA_W-1:0] reg_rdata,
  input wire logic fault_present,
  input wire logic conv_busy,
  input wire logic [N_CELLS-1:0] per_cell_balance_config,
  input wire logic [N_CELLS-1:0] balance_switch_on,
  input wire logic balance_timer_run,
  input wire logic fault_pin,
  input wire logic diagnostic_active_flag,
  input wire logic measure_start,
  input wire logic soft_reset_pulse
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Writes landing in the pulse cycle are dropped by the design
  logic wr_ok;
  assign wr_ok = ce && reg_wr && reg_addr == `SCOC_REG_ADDR && !soft_reset_pulse;
  a_diag_enter: assert property (wr_ok && reg_wdata[6] && reg_wdata[12:10] != 3'h0 |=> diagnostic_active_flag)
    else $error("diagnostic entry not taken");
  a_diag_refuse: assert property (wr_ok && reg_wdata[12:10] == 3'h0 && !diagnostic_active_flag |=> !diagnostic_active_flag)
    else $error("diagnostic entry with zero timeout");
  a_diag_leave: assert property (wr_ok && !reg_wdata[6] |=> !diagnostic_active_flag)
    else $error("diagnostic exit not taken");
  a_status_read: assert property (ce && reg_rd && reg_addr == `SCOC_REG_ADDR |=> reg_rdata[6] == $past(diagnostic_active_flag))
    else $error("status bit differs from flag");
  a_srst_zero: assert property (reg_rdata[4] == 1'b0)
    else $error("reset bit reads one");
  a_srst_cause: assert property (soft_reset_pulse |-> $past(wr_ok && reg_wdata[4]))
    else $error("reset pulse without write");
  a_srst_restore: assert property (ce && soft_reset_pulse |=> !soft_reset_pulse && !diagnostic_active_flag)
    else $error("reset pulse too long or flag kept");
  a_bal_gate: assert property (ce |=> (balance_switch_on & ~$past(per_cell_balance_config)) == '0
    && (balance_switch_on == '0 || balance_timer_run))
    else $error("switch on without request or enable");
  a_fault_level: assert property ($past(rstn) && $past(ce) && $past(fault_present) |-> fault_pin)
    else $error("fault pin low during fault");
  a_start_single: assert property (measure_start |=> !measure_start)
    else $error("launch pulse longer than one cycle");
endmodule
bind scoc_top scoc_top_chk #(.N_CELLS(N_CELLS)) u_chk (.mclk(mclk), .rstn(rstn), .ce(ce), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .fault_present(fault_present), .conv_busy(conv_busy), .per_cell_balance_config(per_cell_balance_config),
  .balance_switch_on(balance_switch_on), .balance_timer_run(balance_timer_run), .fault_pin(fault_pin),
  .diagnostic_active_flag(diagnostic_active_flag), .measure_start(measure_start),
  .soft_reset_pulse(soft_reset_pulse));

//--- test/system_config_one_control_test.sv
`timescale 1ns/10ps
module system_config_one_control_test;
  // ------------------------------------------------------------
  // Shortened times, cycles per code
  // ------------------------------------------------------------
  localparam int NC = 14;
  localparam int T[8] = '{0, 20, 40, 80, 200, 300, 400, 500};
  localparam int HBH = 10;
  localparam int HBL[4] = '{10, 20, 30, 40};
  logic mclk = 0;
  logic rstn = 0;
  logic ce = 1;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic fault_present = 0;
  logic conv_busy = 0;
  logic [7:0] reg_addr = 8'h03;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] rd_val;
  logic [15:0] d;
  logic [15:0] wv;
  logic [NC-1:0] cfg = '0;
  logic [NC-1:0] sw_on;
  logic timer_run, pin, flag, mstart, srst;
  logic [31:0] rs = 32'h00001ae4;
  int n_errors = 0;
  int tests_run = 0;
  int n;
  always #50 mclk = ~mclk;
  scoc_top #(.N_CELLS(NC), .CYC_50MS(T[1]), .CYC_100MS(T[2]), .CYC_200MS(T[3]), .CYC_1S(T[4]),
    .CYC_2S(T[5]), .CYC_4S(T[6]), .CYC_8S(T[7]), .CYC_HB_HIGH(HBH), .CYC_HB_L0(HBL[0]),
    .CYC_HB_L1(HBL[1]), .CYC_HB_L2(HBL[2]), .CYC_HB_L3(HBL[3])) dut (.mclk(mclk), .rstn(rstn), .ce(ce),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(rd_val),
    .fault_present(fault_present), .conv_busy(conv_busy), .per_cell_balance_config(cfg),
    .balance_switch_on(sw_on), .balance_timer_run(timer_run), .fault_pin(pin),
    .diagnostic_active_flag(flag), .measure_start(mstart), .soft_reset_pulse(srst));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  function automatic logic sel(int k);
    return k == 0 ? flag : (k == 1 ? mstart : pin);
  endfunction
  task automatic step(int k);
    repeat (k) begin
      @(posedge mclk);
      #1;
    end
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Strobes drop by non-blocking assignment so a following access may raise them at +1 ns
  task automatic wr(logic [15:0] v);
    reg_wr = 1;
    reg_wdata = v;
    @(posedge mclk);
    reg_wr <= 0;
    #1;
  endtask
  task automatic rd(logic [7:0] a);
    reg_addr = a;
    reg_rd = 1;
    @(posedge mclk);
    reg_rd <= 0;
    reg_addr <= 8'h03;
    #1;
    d = rd_val;
  endtask
  // Length of the run of one output at a level, capped so a stuck output cannot hang
  task automatic run_len(int k, logic v);
    n = 0;
    while (sel(k) === v && n < 1200) begin
      step(1);
      n++;
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    n_errors++;
    report_and_stop();
  end
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    step(8);
    rstn = 1;
    rd(8'h03);
    chk("reset image", 16'h1001, d);
    rd(8'h21);
    chk("unmapped read", 16'h0000, d);
    repeat (6) begin
      rs = rnd();
      // Read-modify-write: reserved bits go back as last read
      wv = (rs[15:0] & 16'hfcaf) | (d & 16'h0300);
      wr(wv);
      rd(8'h03);
      chk("image", wv, d);
    end
    $display("done registers");
    for (int i = 0; i < 8; i++) begin
      cfg = NC'(rnd());
      wr({8'h10, i[0], 1'b0, i[1], 5'h00});
      step(1);
      chk("switches", cfg & {NC{i[0] & !i[1]}}, sw_on);
      chk("timer run", i[0], timer_run);
    end
    $display("done balancing");
    wr(16'h0040);
    chk("diag refused", 1'b0, flag);
    for (int c = 1; c < 8; c++) begin
      wr({3'h0, c[2:0], 10'h040});
      chk("diag entry", 1'b1, flag);
      run_len(0, 1);
      chk("diag timeout", 1'b1, n >= T[c] - 2 && n <= T[c] + 1);
    end
    wr(16'h0440);
    step(12);
    wr(16'h0440);
    rd(8'h03);
    chk("diag status", 1'b1, d[6]);
    run_len(0, 1);
    chk("diag reload", 1'b1, n >= T[1] - 3 && n <= T[1]);
    wr(16'h0440);
    ce = 0;
    step(3 * T[1]);
    ce = 1;
    chk("diag frozen", 1'b1, flag);
    wr(16'h0400);
    chk("diag exit", 1'b0, flag);
    $display("done diagnostic");
    for (int c = 2; c < 8; c++) begin
      wr({c[2:0], 13'h1000});
      run_len(1, 0);
      step(1);
      run_len(1, 0);
      chk("launch period", 1'b1, n >= T[c] - 2 && n <= T[c]);
    end
    conv_busy = 1;
    wr(16'h3000);
    run_len(1, 0);
    chk("busy no launch", 1200, n);
    conv_busy = 0;
    run_len(1, 0);
    chk("continuous", 1'b1, n < 4);
    wr(16'h1000);
    run_len(1, 0);
    chk("launch off", 1200, n);
    $display("done cyclic");
    fault_present = 1;
    step(2);
    chk("fault level", 1'b1, pin);
    fault_present = 0;
    step(2);
    chk("no fault level", 1'b0, pin);
    for (int c = 0; c < 4; c++) begin
      wr({12'h100, 1'b1, c[1:0], 1'b0});
      run_len(2, 1);
      run_len(2, 0);
      run_len(2, 1);
      chk("beat high", HBH, n);
      run_len(2, 0);
      chk("beat low", HBL[c], n);
    end
    fault_present = 1;
    step(HBH + HBL[3]);
    chk("beat stopped", 1'b1, pin);
    fault_present = 0;
    $display("done fault pin");
    wr(16'he4aa & 16'hffaf);
    wr(16'h0010);
    chk("reset pulse", 1'b1, srst);
    step(1);
    rd(8'h03);
    chk("after soft reset", 16'h1001, d);
    wr(16'h0010);
    chk("second pulse", 1'b1, srst);
    $display("done soft reset");
    report_and_stop();
  end
endmodule
